//--- rtl/bfr_alu.sv
// banked file register core: 8-bit alu, two's complement arithmetic
// assumes a is the accumulator and b the file or literal operand
`timescale 1ns/1ns
module bfr_alu (
  // operands
  input  bfr_pkg::bfr_alu_op_e op_in,
  input  logic [7:0]           a_in,
  input  logic [7:0]           b_in,
  input  logic                 cin_in,
  // result
  output logic [7:0]           res_out,
  output bfr_pkg::bfr_flags_s  flg_out,
  output bfr_pkg::bfr_flags_s  upd_out
);
  import bfr_pkg::*;

  logic [8:0] sum9;
  logic [4:0] nib5;

  always_comb begin
    sum9    = 9'h000;
    nib5    = 5'h00;
    res_out = a_in;
    flg_out = '0;
    upd_out = '0;
    unique case (op_in)
      ALU_PASS_A: res_out = a_in;
      ALU_LOAD:   res_out = b_in;
      ALU_PASS_B: begin res_out = b_in;          upd_out.z = 1'b1; end
      ALU_AND:    begin res_out = a_in & b_in;   upd_out.z = 1'b1; end
      ALU_IOR:    begin res_out = a_in | b_in;   upd_out.z = 1'b1; end
      ALU_XOR:    begin res_out = a_in ^ b_in;   upd_out.z = 1'b1; end
      ALU_COM:    begin res_out = ~b_in;         upd_out.z = 1'b1; end
      ALU_INC:    begin res_out = b_in + 8'h01;  upd_out.z = 1'b1; end
      ALU_DEC:    begin res_out = b_in - 8'h01;  upd_out.z = 1'b1; end
      ALU_CLR:    begin res_out = 8'h00;         upd_out.z = 1'b1; end
      ALU_SWAP:   res_out = {b_in[3:0], b_in[7:4]};
      ALU_ADD: begin
        sum9       = {1'b0, a_in} + {1'b0, b_in};
        nib5       = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
        res_out    = sum9[7:0];
        flg_out.c  = sum9[8];
        flg_out.dc = nib5[4];
        upd_out    = '1;
      end
      ALU_SUB: begin
        // b minus a; carry and nibble carry read as not-borrow
        sum9       = {1'b0, b_in} + {1'b0, ~a_in} + 9'h001;
        nib5       = {1'b0, b_in[3:0]} + {1'b0, ~a_in[3:0]} + 5'h01;
        res_out    = sum9[7:0];
        flg_out.c  = sum9[8];
        flg_out.dc = nib5[4];
        upd_out    = '1;
      end
      ALU_RR: begin
        res_out   = {cin_in, b_in[7:1]};
        flg_out.c = b_in[0];
        upd_out.c = 1'b1;
      end
      ALU_RL: begin
        res_out   = {b_in[6:0], cin_in};
        flg_out.c = b_in[7];
        upd_out.c = 1'b1;
      end
      default: res_out = a_in;
    endcase
    flg_out.z = (res_out == 8'h00);
  end

endmodule

//--- rtl/bfr_core.sv
////////////////////////////////////////////////////////////////////////////////
// banked file register core: fetch, pipeline, alu datapath and data memory
// assumes program memory answers prog_addr_out within the same cycle and
// that the register port strobes are one cycle long and never both high
//
// Operation
// - fetch one 14-bit word per cycle
// - fetch next while current one executes
// - one cycle each; branches refill pipeline
// - program counter spans 512, 1K, 2K words
// - special registers, pc included, in data map
// - 8-bit alu: add, subtract, shift, logic
// - operands: accumulator with file or literal
// - accumulator is 8 bits, not addressable
// - alu updates carry, nibble carry, zero
// - subtraction: carries mean not-borrow
// - bank_select_bit chooses bank 0 or 1
// - special registers fill first 32 locations
// - ram at 20h-7Fh, large parts A0h-BFh
// - F0h-FFh alias 70h-7Fh on revised parts
// - ram holds 80, 96 or 128 bytes
// - every gpr reachable direct and indirect
// - unimplemented locations read as zero
////////////////////////////////////////////////////////////////////////////////
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module bfr_core #(
  parameter int   PROG_WORDS = bfr_pkg::PROG_WORDS_DEF,
  parameter int   GPR_BYTES  = bfr_pkg::GPR_BYTES_DEF,
  parameter logic HAS_ALIAS  = 1'b1,
  localparam int  PC_W       = $clog2(PROG_WORDS)
) (
  // clock and reset
  input  logic                          sys_clk_in,
  input  logic                          nrst_in,
  // program memory bus
  output logic [PC_W-1:0]               prog_addr_out,
  input  logic [bfr_pkg::INSN_W-1:0]    prog_data_in,
  // register port
  input  bfr_pkg::bfr_dbg_req_s         dbg_req_in,
  output logic [bfr_pkg::DATA_W-1:0]    dbg_rdata_out,
  // core state
  output logic [bfr_pkg::DATA_W-1:0]    acc_out,
  output logic [bfr_pkg::DATA_W-1:0]    status_out
);
  import bfr_pkg::*;

  localparam int B0_SIZE = (GPR_BYTES > GPR_B0_MAX) ? GPR_B0_MAX : GPR_BYTES;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic              phase_reg;
  logic [PC_W-1:0]   pc_reg;
  logic [INSN_W-1:0] ir_reg;
  logic              ir_valid_reg;
  logic [7:0]        acc_reg;
  logic [7:0]        status_reg;
  logic [7:0]        status_next;
  logic [7:0]        ptr_reg;
  logic [4:0]        pclath_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // decode and datapath signals

  logic              stall;
  logic              exec;
  bfr_alu_op_e       alu_op;
  logic              use_lit;
  logic              dest_f;
  logic              dest_w;
  logic              is_goto;
  logic [7:0]        operand;
  logic [7:0]        alu_res;
  bfr_flags_s        alu_flg;
  bfr_flags_s        alu_upd;
  logic [7:0]        core_addr;
  logic [7:0]        mem_addr;
  logic [IDX_W:0]    mem_map;
  logic              gpr_hit;
  logic              sfr_hit;
  logic [7:0]        sfr_rdata;
  logic [7:0]        wr_data;
  logic              wr_req;
  logic              ram_we;
  logic              sfr_we;
  logic              pcl_we;
  logic              flush;
  logic [PC_W-1:0]   flush_target;
  logic [7:0]        ram_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // data address map

  // returns {hit, ram index} for a full 8-bit file address
  function automatic logic [IDX_W:0] gpr_map(input logic [7:0] a);
    logic [7:0]     off;
    logic [IDX_W:0] r;
    off = 8'h00;
    r   = '0;
    if (!a[7] && a >= GPR_B0_BASE) begin
      off = a - GPR_B0_BASE;
      if (off < 8'(B0_SIZE)) begin
        r = {1'b1, off[IDX_W-1:0]};
      end
    end else if (a >= GPR_B1_BASE && a <= GPR_B1_LAST && GPR_BYTES == GPR_FULL) begin
      off = a - GPR_B1_BASE + 8'(GPR_B0_MAX);
      r   = {1'b1, off[IDX_W-1:0]};
    end else if (a >= ALIAS_BASE && HAS_ALIAS && B0_SIZE == GPR_B0_MAX) begin
      off = a - ALIAS_BASE + (ALIAS_TGT - GPR_B0_BASE);
      r   = {1'b1, off[IDX_W-1:0]};
    end
    return r;
  endfunction

  // file field 0 follows the pointer, any other field is banked direct
  always_comb begin
    if (ir_reg[6:0] == SFR_IND) begin
      core_addr = ptr_reg;
    end else begin
      core_addr = {status_reg[ST_BANK], ir_reg[6:0]};
    end
  end

  // a register port access borrows the memory for its cycle
  assign stall    = dbg_req_in.wr | dbg_req_in.rd;
  assign mem_addr = stall ? dbg_req_in.addr : core_addr;
  assign mem_map  = gpr_map(mem_addr);
  assign gpr_hit  = mem_map[IDX_W];
  assign sfr_hit  = (mem_addr[6:0] <= SFR_TOP);

  // special registers answer in both banks; gaps and the indirect slot 00h read 0
  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_hit) begin
      case (mem_addr[6:0])
        SFR_PCL:    sfr_rdata = pc_reg[7:0];
        SFR_STATUS: sfr_rdata = status_reg;
        SFR_PTR:    sfr_rdata = ptr_reg;
        SFR_PCLATH: sfr_rdata = {3'h0, pclath_reg};
        default:    sfr_rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instruction cycle: phase 0 reads the operand, phase 1 executes

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      phase_reg <= 1'b0;
    end else if (stall) begin
      // the stolen read is replayed, so restart the read phase
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  assign exec = phase_reg & ~stall;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  always_comb begin
    alu_op  = ALU_PASS_A;
    use_lit = 1'b0;
    dest_f  = 1'b0;
    dest_w  = 1'b0;
    is_goto = 1'b0;
    if (ir_valid_reg) begin
      unique case (ir_reg[13:12])
        CLS_BYTE: begin
          dest_f = ir_reg[7];
          dest_w = ~ir_reg[7];
          case (bfr_bop_e'(ir_reg[11:8]))
            BOP_MOVWF: begin
              alu_op = ALU_PASS_A;
              dest_w = 1'b0;
            end
            BOP_CLR:  alu_op = ALU_CLR;
            BOP_SUB:  alu_op = ALU_SUB;
            BOP_DEC:  alu_op = ALU_DEC;
            BOP_IOR:  alu_op = ALU_IOR;
            BOP_AND:  alu_op = ALU_AND;
            BOP_XOR:  alu_op = ALU_XOR;
            BOP_ADD:  alu_op = ALU_ADD;
            BOP_MOV:  alu_op = ALU_PASS_B;
            BOP_COM:  alu_op = ALU_COM;
            BOP_INC:  alu_op = ALU_INC;
            BOP_RR:   alu_op = ALU_RR;
            BOP_RL:   alu_op = ALU_RL;
            BOP_SWAP: alu_op = ALU_SWAP;
            default: begin
              dest_f = 1'b0;
              dest_w = 1'b0;
            end
          endcase
        end
        CLS_LIT: begin
          use_lit = 1'b1;
          dest_w  = 1'b1;
          case (bfr_lop_e'(ir_reg[11:8]))
            LOP_MOV: alu_op = ALU_LOAD;
            LOP_IOR: alu_op = ALU_IOR;
            LOP_AND: alu_op = ALU_AND;
            LOP_XOR: alu_op = ALU_XOR;
            LOP_SUB: alu_op = ALU_SUB;
            LOP_ADD: alu_op = ALU_ADD;
            default: dest_w = 1'b0;
          endcase
        end
        CLS_CTRL: is_goto = ir_reg[11];
        default:  is_goto = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // alu

  assign operand = use_lit ? ir_reg[7:0] : ram_rdata;

  bfr_alu u_alu (
    .op_in   (alu_op),
    .a_in    (acc_reg),
    .b_in    (operand),
    .cin_in  (status_reg[ST_C]),
    .res_out (alu_res),
    .flg_out (alu_flg),
    .upd_out (alu_upd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // data memory writes

  assign wr_req  = stall ? dbg_req_in.wr : (exec & dest_f);
  assign wr_data = stall ? dbg_req_in.wdata : alu_res;
  assign ram_we  = wr_req & gpr_hit;
  assign sfr_we  = wr_req & ~gpr_hit & sfr_hit;
  assign pcl_we  = sfr_we & (mem_addr[6:0] == SFR_PCL);

  bfr_gpr_ram #(
    .DEPTH (GPR_BYTES),
    .AW    (IDX_W)
  ) u_ram (
    .sys_clk_in  (sys_clk_in),
    .nrst_in     (nrst_in),
    .we_in       (ram_we),
    .waddr_in    (mem_map[IDX_W-1:0]),
    .wdata_in    (wr_data),
    .raddr_in    (mem_map[IDX_W-1:0]),
    .byp_in      (~gpr_hit),
    .byp_data_in (sfr_rdata),
    .rdata_out   (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // accumulator

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      acc_reg <= ACC_RST;
    end else if (exec && dest_w) begin
      acc_reg <= alu_res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status: flags from the alu win over a direct write in the same cycle

  always_comb begin
    status_next = status_reg;
    if (sfr_we && mem_addr[6:0] == SFR_STATUS) begin
      status_next = wr_data & STATUS_WMASK;
    end
    if (exec) begin
      if (alu_upd.c) begin
        status_next[ST_C] = alu_flg.c;
      end
      if (alu_upd.dc) begin
        status_next[ST_DC] = alu_flg.dc;
      end
      if (alu_upd.z) begin
        status_next[ST_Z] = alu_flg.z;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      status_reg <= STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pointer and program counter latch

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      ptr_reg <= PTR_RST;
    end else if (sfr_we && mem_addr[6:0] == SFR_PTR) begin
      ptr_reg <= wr_data;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pclath_reg <= PCLATH_RST;
    end else if (sfr_we && mem_addr[6:0] == SFR_PCLATH) begin
      pclath_reg <= wr_data[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fetch and pipeline

  assign flush = pcl_we | (exec & is_goto);

  always_comb begin
    if (pcl_we) begin
      flush_target = PC_W'({pclath_reg, wr_data});
    end else begin
      flush_target = PC_W'(ir_reg[10:0]);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pc_reg       <= '0;
      ir_reg       <= INSN_RST;
      ir_valid_reg <= 1'b0;
    end else if (flush) begin
      // the word already fetched is dropped and fetching restarts
      pc_reg       <= flush_target;
      ir_valid_reg <= 1'b0;
    end else if (exec) begin
      ir_reg       <= prog_data_in;
      ir_valid_reg <= 1'b1;
      pc_reg       <= pc_reg + PC_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prog_addr_out = pc_reg;
  assign dbg_rdata_out = ram_rdata;
  assign acc_out       = acc_reg;
  assign status_out    = status_reg;

endmodule

//--- rtl/bfr_gpr_ram.sv
// banked file register core: general purpose ram with registered read
// assumes one write and one read per cycle; bypass loads non-ram read data
`timescale 1ns/1ns
module bfr_gpr_ram #(
  parameter int DEPTH = 96,
  parameter int AW    = 7
) (
  // clock and reset
  input  logic          sys_clk_in,
  input  logic          nrst_in,
  // write port
  input  logic          we_in,
  input  logic [AW-1:0] waddr_in,
  input  logic [7:0]    wdata_in,
  // read port
  input  logic [AW-1:0] raddr_in,
  input  logic          byp_in,
  input  logic [7:0]    byp_data_in,
  output logic [7:0]    rdata_out
);

  logic [7:0] mem_reg [DEPTH];
  logic [7:0] rdata_reg;

  always_ff @(posedge sys_clk_in) begin
    if (we_in) begin
      mem_reg[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= byp_in ? byp_data_in : mem_reg[raddr_in];
    end
  end

  assign rdata_out = rdata_reg;

endmodule

//--- rtl/bfr_pkg.sv
// banked file register core: shared constants, encodings and carrier types
// assumes one core clock domain; all users import the whole package
package bfr_pkg;

  // datapath widths
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int IDX_W  = 7;

  // special registers, mirrored into both banks on the low seven address bits
  localparam logic [6:0] SFR_IND    = 7'h00;
  localparam logic [6:0] SFR_PCL    = 7'h02;
  localparam logic [6:0] SFR_STATUS = 7'h03;
  localparam logic [6:0] SFR_PTR    = 7'h04;
  localparam logic [6:0] SFR_PCLATH = 7'h0A;
  localparam logic [6:0] SFR_TOP    = 7'h1F;

  // status layout and reset values
  localparam int         ST_C         = 0;
  localparam int         ST_DC        = 1;
  localparam int         ST_Z         = 2;
  localparam int         ST_BANK      = 5;
  localparam logic [7:0] STATUS_WMASK = 8'h27;
  localparam logic [7:0] STATUS_RST   = 8'h00;
  localparam logic [7:0] ACC_RST      = 8'h00;
  localparam logic [7:0] PTR_RST      = 8'h00;
  localparam logic [4:0] PCLATH_RST   = 5'h00;
  localparam logic [13:0] INSN_RST    = 14'h0000;

  // general purpose ram placement
  localparam logic [7:0] GPR_B0_BASE = 8'h20;
  localparam logic [7:0] GPR_B1_BASE = 8'hA0;
  localparam logic [7:0] GPR_B1_LAST = 8'hBF;
  localparam logic [7:0] ALIAS_BASE  = 8'hF0;
  localparam logic [7:0] ALIAS_TGT   = 8'h70;
  localparam int         GPR_B0_MAX  = 96;
  localparam int         GPR_FULL    = 128;

  // variant defaults
  localparam int PROG_WORDS_DEF = 512;
  localparam int GPR_BYTES_DEF  = 96;

  // instruction classes in bits 13:12
  localparam logic [1:0] CLS_BYTE = 2'b00;
  localparam logic [1:0] CLS_CTRL = 2'b10;
  localparam logic [1:0] CLS_LIT  = 2'b11;

  typedef enum logic [3:0] {
    BOP_MOVWF = 4'h0, BOP_CLR = 4'h1, BOP_SUB = 4'h2, BOP_DEC = 4'h3,
    BOP_IOR   = 4'h4, BOP_AND = 4'h5, BOP_XOR = 4'h6, BOP_ADD = 4'h7,
    BOP_MOV   = 4'h8, BOP_COM = 4'h9, BOP_INC = 4'hA, BOP_RR  = 4'hC,
    BOP_RL    = 4'hD, BOP_SWAP = 4'hE
  } bfr_bop_e;

  typedef enum logic [3:0] {
    LOP_MOV = 4'h0, LOP_IOR = 4'h8, LOP_AND = 4'h9,
    LOP_XOR = 4'hA, LOP_SUB = 4'hC, LOP_ADD = 4'hE
  } bfr_lop_e;

  typedef enum logic [3:0] {
    ALU_PASS_A = 4'h0, ALU_LOAD = 4'h1, ALU_PASS_B = 4'h2, ALU_ADD = 4'h3,
    ALU_SUB    = 4'h4, ALU_AND  = 4'h5, ALU_IOR    = 4'h6, ALU_XOR = 4'h7,
    ALU_COM    = 4'h8, ALU_INC  = 4'h9, ALU_DEC    = 4'hA, ALU_RR  = 4'hB,
    ALU_RL     = 4'hC, ALU_SWAP = 4'hD, ALU_CLR    = 4'hE
  } bfr_alu_op_e;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } bfr_flags_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bfr_dbg_req_s;

endpackage

//--- verif/bfr_core_asserts.sv
// bfr_core checker: port-level assertions and covers, bound into the core
// assumes the pc high latch is zero whenever pc low is written, so pc loads take the byte as is
`timescale 1ns/1ns
module bfr_core_asserts #(
  parameter int   PROG_WORDS = 512,
  parameter int   GPR_BYTES  = 96,
  parameter logic HAS_ALIAS  = 1'b1,
  localparam int  PC_W       = $clog2(PROG_WORDS)
) (
  // clock and reset
  input logic                  sys_clk_in,
  input logic                  nrst_in,
  // watched ports
  input logic [PC_W-1:0]       prog_addr_out,
  input logic [13:0]           prog_data_in,
  input bfr_pkg::bfr_dbg_req_s dbg_req_in,
  input logic [7:0]            dbg_rdata_out,
  input logic [7:0]            acc_out,
  input logic [7:0]            status_out
);
  import bfr_pkg::*;

  localparam logic [7:0] B1_HOLE = (GPR_BYTES == 128) ? 8'hC0 : 8'hA0;

  logic       req;
  logic [7:0] sfr;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  assign req = dbg_req_in.wr | dbg_req_in.rd;
  assign sfr = {1'b0, dbg_req_in.addr[6:0]};

  ////////////////////////////////////////////////////////////////////////////
  // common-ram write followed by a read of its bank 0 twin
  sequence alias_wr_rd;
    dbg_req_in.wr && dbg_req_in.addr[7:4] == 4'hF ##1
    dbg_req_in.rd && dbg_req_in.addr == $past(dbg_req_in.addr) - 8'h80;
  endsequence

  a_status_pad: assert property (status_out[7:6] == 2'b00 && status_out[4:3] == 2'b00)
    else $error("status spare bits set");
  a_acc_port_safe: assert property (req |=> $stable(acc_out))
    else $error("port access moved the accumulator");
  a_fetch_pace: assert property ($changed(prog_addr_out) && !req |=> $stable(prog_addr_out))
    else $error("fetch address moved twice in one instruction cycle");
  a_pc_load: assert property (dbg_req_in.wr && sfr == 8'h02 |=>
    prog_addr_out == PC_W'($past(dbg_req_in.wdata)))
    else $error("pc low write did not load the fetch address");
  a_sfr_blank: assert property (dbg_req_in.rd && sfr <= 8'h1F &&
    !(sfr inside {8'h02, 8'h03, 8'h04, 8'h0A}) |=> dbg_rdata_out == 8'h00)
    else $error("empty special slot read nonzero");
  a_bank1_hole: assert property (dbg_req_in.rd && dbg_req_in.addr >= B1_HOLE &&
    dbg_req_in.addr <= 8'hEF |=> dbg_rdata_out == 8'h00)
    else $error("unbacked bank 1 address read nonzero");
  a_status_both: assert property (dbg_req_in.rd && sfr == 8'h03 |=>
    dbg_rdata_out == $past(status_out))
    else $error("status read differs from status");
  a_status_mask: assert property (dbg_req_in.wr && sfr == 8'h03 |=>
    status_out == ($past(dbg_req_in.wdata) & STATUS_WMASK))
    else $error("status write not masked");
  a_ptr_back: assert property (dbg_req_in.wr && sfr == 8'h04 ##1
    dbg_req_in.rd && sfr == 8'h04 |=> dbg_rdata_out == $past(dbg_req_in.wdata, 2))
    else $error("pointer read back wrong");
  a_alias_map: assert property (((HAS_ALIAS && GPR_BYTES >= 96) and alias_wr_rd) |=>
    dbg_rdata_out == $past(dbg_req_in.wdata, 2))
    else $error("common ram twin differs");

  c_pc_restart: cover property (dbg_req_in.wr && sfr == 8'h02);
  c_alias: cover property (alias_wr_rd);
  c_flags_all: cover property (status_out[2:0] == 3'b111);
endmodule

bind bfr_core bfr_core_asserts #(
  .PROG_WORDS(PROG_WORDS),
  .GPR_BYTES (GPR_BYTES),
  .HAS_ALIAS (HAS_ALIAS)
) u_asserts (
  .sys_clk_in   (sys_clk_in),
  .nrst_in      (nrst_in),
  .prog_addr_out(prog_addr_out),
  .prog_data_in (prog_data_in),
  .dbg_req_in   (dbg_req_in),
  .dbg_rdata_out(dbg_rdata_out),
  .acc_out      (acc_out),
  .status_out   (status_out)
);

//--- verif/bfr_core_bench.sv
// bfr_core bench: register-port traffic and short programs from a model rom
// assumes the rom answers combinationally and pc high latch is zero at every pc low write
`timescale 1ns/1ns
module bfr_core_bench;
  import bfr_pkg::*;

  localparam int PW  = 512;
  localparam int PCW = $clog2(PW);

  logic           sys_clk_in;
  logic           nrst_in;
  logic [PCW-1:0] prog_addr_out;
  logic [13:0]    prog_data_in;
  bfr_dbg_req_s   dbg_req_in;
  logic [7:0]     dbg_rdata_out;
  logic [7:0]     acc_out;
  logic [7:0]     status_out;
  logic [13:0]    prog_mem [PW];
  logic [7:0]     exp_q [$];
  logic [7:0]     holes [5] = '{8'hA0, 8'h80, 8'h05, 8'h1F, 8'hC3};
  logic           rd_d;
  logic [7:0]     ad, v, l, a, k;
  logic [8:0]     e;
  int             n_fail = 0;
  int             n_tests = 0;
  int             cyc = 0;

  assign prog_data_in = prog_mem[prog_addr_out];

  bfr_core #(.PROG_WORDS(PW), .GPR_BYTES(96), .HAS_ALIAS(1'b1)) uut (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .prog_addr_out(prog_addr_out),
    .prog_data_in (prog_data_in),
    .dbg_req_in   (dbg_req_in),
    .dbg_rdata_out(dbg_rdata_out),
    .acc_out      (acc_out),
    .status_out   (status_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected {carry, accumulator} after loading p and running operation o;
  // o below 16 is a byte op on file value x, o from 16 a literal op with m
  function automatic logic [8:0] op_exp(input int o, input logic [7:0] p, x, m);
    logic c;
    c = m[0];
    case (o)
      1:       return {c, 8'h00};
      2:       return {x >= p, x - p};
      3:       return {c, x - 8'h01};
      4:       return {c, p | x};
      5:       return {c, p & x};
      6:       return {c, p ^ x};
      7:       return {1'b0, x} + {1'b0, p};
      8:       return {c, x};
      9:       return {c, ~x};
      10:      return {c, x + 8'h01};
      12:      return {x[0], c, x[7:1]};
      13:      return {x[7], x[6:0], c};
      14:      return {c, x[3:0], x[7:4]};
      16:      return {c, m};
      24:      return {c, p | m};
      25:      return {c, p & m};
      26:      return {c, p ^ m};
      28:      return {m >= p, m - p};
      30:      return {1'b0, m} + {1'b0, p};
      default: return {c, p};
    endcase
  endfunction

  // one strobe cycle; back to back calls keep the bus busy without a gap
  task automatic req(input logic w, input logic r, input logic [7:0] ad_i, input logic [7:0] d);
    dbg_req_in <= '{wr: w, rd: r, addr: ad_i, wdata: d};
    @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [7:0] ad_i, input logic [7:0] d);
    req(1'b1, 1'b0, ad_i, d);
  endtask

  task automatic rd(input logic [7:0] ad_i, input logic [7:0] exp);
    exp_q.push_back(exp);
    req(1'b0, 1'b1, ad_i, 8'h00);
  endtask

  task automatic idle(input int n);
    dbg_req_in <= '0;
    repeat (n) @(posedge sys_clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk_in) rd_d <= nrst_in & dbg_req_in.rd;
  always @(negedge sys_clk_in) begin
    if (rd_d === 1'b1) cmp(dbg_rdata_out, exp_q.pop_front());
  end

  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    nrst_in = 1'b0;
    dbg_req_in = '0;
    foreach (prog_mem[i]) prog_mem[i] = 14'h0000;
    prog_mem[5] = 14'h2805;
    void'($urandom(75437));
    repeat (5) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(negedge sys_clk_in);
    cmp(acc_out, ACC_RST);
    cmp(status_out, STATUS_RST);
    @(posedge sys_clk_in);
    // bank 0 ram: both ends, then random places
    for (int i = 0; i < 8; i++) begin
      ad = (i == 0) ? 8'h20 : (i == 1) ? 8'h7F : 8'h20 + 8'($urandom_range(95));
      v = 8'($urandom);
      wr(ad, v);
      rd(ad, v);
    end
    wr(8'hA0, 8'h5A);
    foreach (holes[j]) rd(holes[j], 8'h00);
    v = 8'($urandom);
    wr(8'hF5, v);
    rd(8'h75, v);
    wr(8'h7A, ~v);
    rd(8'hFA, ~v);
    wr(8'h04, 8'h3C);
    rd(8'h04, 8'h3C);
    rd(8'h84, 8'h3C);
    wr(8'h0A, 8'hFF);
    rd(8'h8A, 8'h1F);
    wr(8'h0A, 8'h00);
    wr(8'h83, 8'hFF);
    rd(8'h03, 8'h27);
    // load, add, store direct and indirect, subtract, then spin
    for (int i = 0; i < 4; i++) begin
      l = 8'($urandom);
      a = l + 8'h01;
      k = (i == 3) ? a : 8'($urandom);
      prog_mem[0] = 14'h3000 | 14'(l);
      prog_mem[1] = 14'h3E01;
      prog_mem[2] = 14'h00A5;
      prog_mem[3] = 14'h0080;
      prog_mem[4] = 14'h3C00 | 14'(k);
      wr(8'h25, 8'h55);
      wr(8'h04, 8'h30 + 8'(i));
      wr(8'h03, {2'b00, i[0], 5'h00});
      wr(8'h02, 8'h00);
      idle(30);
      @(negedge sys_clk_in);
      cmp(acc_out, k - a);
      cmp(status_out, {2'b00, i[0], 2'b00, k == a, k[3:0] >= a[3:0], k >= a});
      cmp(prog_addr_out[7:0], 8'h05);
      @(posedge sys_clk_in);
      rd(8'h25, i[0] ? 8'h55 : a);
      rd(8'h30 + 8'(i), a);
    end
    // one byte or literal operation per run, carry in taken from status
    for (int o = 0; o < 32; o++) begin
      l = 8'($urandom);
      v = 8'($urandom);
      k = 8'($urandom);
      prog_mem[0] = 14'h3000 | 14'(l);
      prog_mem[1] = (o < 16) ? (14'(o << 8) | 14'h0026)
                             : (14'h3000 | 14'((o - 16) << 8) | 14'(k));
      prog_mem[2] = 14'h2802;
      e = op_exp(o, l, v, k);
      wr(8'h26, v);
      wr(8'h03, {7'h00, k[0]});
      wr(8'h02, 8'h00);
      idle(12);
      @(negedge sys_clk_in);
      cmp(acc_out, e[7:0]);
      cmp({7'h00, status_out[0]}, {7'h00, e[8]});
      @(posedge sys_clk_in);
    end
    idle(4);
    results();
  end
endmodule
